// ==== hdl/pac_regs.sv ====
`timescale 1ns/1ps
// Function
// - each channel gain register's low seven bits set that channel's gain
// - contrast field applies one common gain to all three channels
// - four level registers each hold a full 8-bit output code
// - scale bit low selects 4.5V range, high selects 2.5V for outputs 1-3
// - mix bit high halves output 4 and adds it to outputs 1-3
// - three-bit field sets common DC offset of video outputs
// - two-bit field selects contrast of overlay graphics
// - global blank bit high forces video outputs to black
// - power save bit high shuts down analog sections
// - two-bit field selects pixel clock loop frequency range
// - vertical blank enable high gates vertical blanking onto outputs
// - self-clearing soft reset reloads other registers, serial transfers unaffected
module pac_regs
  import pac_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic      [6:0]  blue_gain_field_o,
  output logic      [6:0]  green_gain_field_o,
  output logic      [6:0]  red_gain_field_o,
  output logic      [6:0]  contrast_gain_field_o,
  output logic      [7:0]  level_one_code_o,
  output logic      [7:0]  level_two_code_o,
  output logic      [7:0]  level_three_code_o,
  output logic      [7:0]  level_four_code_o,
  output logic             level_scale_select_o,
  output logic             level_four_mix_enable_o,
  output logic      [1:0]  overlay_contrast_field_o,
  output logic      [2:0]  output_black_offset_o,
  output logic             global_blank_o,
  output logic             power_save_o,
  output logic      [1:0]  loop_freq_range_o,
  output logic             vertical_blank_enable_o,
  output logic             auto_inc_disable_o,
  output logic             soft_reset_o
);

  // every configuration field at its reset value; bookkeeping fields untouched
  function automatic pac_state_t with_defaults(input pac_state_t s);
    pac_state_t r;
    r                  = s;
    r.gain_blue        = PAC_GAIN_RST;
    r.gain_green       = PAC_GAIN_RST;
    r.gain_red         = PAC_GAIN_RST;
    r.contrast         = PAC_CONTR_RST;
    r.level_one        = PAC_LEVEL_RST;
    r.level_two        = PAC_LEVEL_RST;
    r.level_three      = PAC_LEVEL_RST;
    r.level_four       = PAC_LEVEL_RST;
    r.scale_sel        = PAC_SCALE_RST;
    r.mix_en           = PAC_MIX_RST;
    r.overlay_contrast = PAC_OSD_RST;
    r.black_offset     = PAC_OFFSET_RST;
    r.blank            = PAC_BLANK_RST;
    r.power_save       = PAC_PSAVE_RST;
    r.freq_range       = PAC_RANGE_RST;
    r.vblank_en        = PAC_VBLANK_RST;
    return r;
  endfunction

  // reserved bit positions always read back as zero
  function automatic logic [7:0] read_byte(input pac_state_t s, input logic [15:0] a);
    logic [7:0] b;
    b = 8'h00;
    unique case (a)
      PAC_ADDR_GAIN_BLUE:  b = {1'b0, s.gain_blue};
      PAC_ADDR_GAIN_GREEN: b = {1'b0, s.gain_green};
      PAC_ADDR_GAIN_RED:   b = {1'b0, s.gain_red};
      PAC_ADDR_CONTRAST:   b = {1'b0, s.contrast};
      PAC_ADDR_LEVEL_ONE:  b = s.level_one;
      PAC_ADDR_LEVEL_TWO:  b = s.level_two;
      PAC_ADDR_LEVEL_THR:  b = s.level_three;
      PAC_ADDR_LEVEL_FOUR: b = s.level_four;
      PAC_ADDR_SCALE_CFG: begin
        b[PAC_MIX_BIT]                  = s.mix_en;
        b[PAC_SCALE_BIT]                = s.scale_sel;
        b[PAC_OSD_MSB:PAC_OSD_LSB]      = s.overlay_contrast;
        b[PAC_OFFSET_MSB:PAC_OFFSET_LSB] = s.black_offset;
      end
      PAC_ADDR_GLOBAL: begin
        b[PAC_PSAVE_BIT] = s.power_save;
        b[PAC_BLANK_BIT] = s.blank;
      end
      PAC_ADDR_RANGE: begin
        b[PAC_VBLANK_BIT]              = s.vblank_en;
        b[PAC_RANGE_MSB:PAC_RANGE_LSB] = s.freq_range;
      end
      PAC_ADDR_RESET_CTL: begin
        b[PAC_AI_DIS_BIT] = s.ai_dis;
        b[PAC_SRESET_BIT] = s.soft_rst;
      end
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  localparam pac_state_t PAC_RST_STATE = '{
    gain_blue:        PAC_GAIN_RST,
    gain_green:       PAC_GAIN_RST,
    gain_red:         PAC_GAIN_RST,
    contrast:         PAC_CONTR_RST,
    level_one:        PAC_LEVEL_RST,
    level_two:        PAC_LEVEL_RST,
    level_three:      PAC_LEVEL_RST,
    level_four:       PAC_LEVEL_RST,
    scale_sel:        PAC_SCALE_RST,
    mix_en:           PAC_MIX_RST,
    overlay_contrast: PAC_OSD_RST,
    black_offset:     PAC_OFFSET_RST,
    blank:            PAC_BLANK_RST,
    power_save:       PAC_PSAVE_RST,
    freq_range:       PAC_RANGE_RST,
    vblank_en:        PAC_VBLANK_RST,
    ai_dis:           PAC_AI_DIS_RST,
    soft_rst:         PAC_SRESET_RST,
    rdata:            PAC_RDATA_RST
  };

  pac_state_t st_q;
  pac_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (reg_rd_i) begin
      st_d.rdata = read_byte(st_q, reg_addr_i);
    end
    if (st_q.soft_rst) begin
      // reset cycle: defaults win over any write landing now; the bus engine
      // itself is outside this bank, so transfers in flight carry on
      st_d          = with_defaults(st_d);
      st_d.soft_rst = 1'b0;
    end else if (reg_wr_i) begin
      // reserved bits are dropped; software is expected to write them as zero
      unique case (reg_addr_i)
        PAC_ADDR_GAIN_BLUE:  st_d.gain_blue   = reg_wdata_i[PAC_GAIN_MSB:0];
        PAC_ADDR_GAIN_GREEN: st_d.gain_green  = reg_wdata_i[PAC_GAIN_MSB:0];
        PAC_ADDR_GAIN_RED:   st_d.gain_red    = reg_wdata_i[PAC_GAIN_MSB:0];
        PAC_ADDR_CONTRAST:   st_d.contrast    = reg_wdata_i[PAC_GAIN_MSB:0];
        PAC_ADDR_LEVEL_ONE:  st_d.level_one   = reg_wdata_i;
        PAC_ADDR_LEVEL_TWO:  st_d.level_two   = reg_wdata_i;
        PAC_ADDR_LEVEL_THR:  st_d.level_three = reg_wdata_i;
        PAC_ADDR_LEVEL_FOUR: st_d.level_four  = reg_wdata_i;
        PAC_ADDR_SCALE_CFG: begin
          st_d.black_offset     = reg_wdata_i[PAC_OFFSET_MSB:PAC_OFFSET_LSB];
          st_d.overlay_contrast = reg_wdata_i[PAC_OSD_MSB:PAC_OSD_LSB];
          st_d.scale_sel        = reg_wdata_i[PAC_SCALE_BIT];
          st_d.mix_en           = reg_wdata_i[PAC_MIX_BIT];
        end
        PAC_ADDR_GLOBAL: begin
          st_d.blank      = reg_wdata_i[PAC_BLANK_BIT];
          st_d.power_save = reg_wdata_i[PAC_PSAVE_BIT];
        end
        PAC_ADDR_RANGE: begin
          st_d.freq_range = reg_wdata_i[PAC_RANGE_MSB:PAC_RANGE_LSB];
          st_d.vblank_en  = reg_wdata_i[PAC_VBLANK_BIT];
        end
        PAC_ADDR_RESET_CTL: begin
          st_d.ai_dis   = reg_wdata_i[PAC_AI_DIS_BIT];
          st_d.soft_rst = reg_wdata_i[PAC_SRESET_BIT];
        end
        default: st_d = st_d;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= PAC_RST_STATE;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o              = st_q.rdata;
  assign blue_gain_field_o        = st_q.gain_blue;
  assign green_gain_field_o       = st_q.gain_green;
  assign red_gain_field_o         = st_q.gain_red;
  assign contrast_gain_field_o    = st_q.contrast;
  assign level_one_code_o         = st_q.level_one;
  assign level_two_code_o         = st_q.level_two;
  assign level_three_code_o       = st_q.level_three;
  assign level_four_code_o        = st_q.level_four;
  assign level_scale_select_o     = st_q.scale_sel;
  assign level_four_mix_enable_o  = st_q.mix_en;
  assign overlay_contrast_field_o = st_q.overlay_contrast;
  assign output_black_offset_o    = st_q.black_offset;
  assign global_blank_o           = st_q.blank;
  assign power_save_o             = st_q.power_save;
  assign loop_freq_range_o        = st_q.freq_range;
  assign vertical_blank_enable_o  = st_q.vblank_en;
  assign auto_inc_disable_o       = st_q.ai_dis;
  assign soft_reset_o             = st_q.soft_rst;

  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence wr_to(logic [15:0] a);
    ce_i && reg_wr_i && !soft_reset_o && reg_addr_i == a;
  endsequence

  sequence soft_rst_req;
    ce_i && reg_wr_i && !soft_reset_o && reg_addr_i == PAC_ADDR_RESET_CTL && reg_wdata_i[PAC_SRESET_BIT];
  endsequence

  sequence soft_rst_done;
    soft_reset_o && ce_i ##1 !soft_reset_o && blue_gain_field_o == PAC_GAIN_RST && !global_blank_o;
  endsequence

  gain_write_a: assert property (wr_to(PAC_ADDR_GAIN_RED) |=>
    red_gain_field_o == $past(reg_wdata_i[6:0])) else $error("red gain not taken from write");

  contrast_write_a: assert property (wr_to(PAC_ADDR_CONTRAST) |=>
    contrast_gain_field_o == $past(reg_wdata_i[6:0])) else $error("contrast not taken from write");

  level_write_a: assert property (wr_to(PAC_ADDR_LEVEL_FOUR) |=>
    level_four_code_o == $past(reg_wdata_i)) else $error("level four code not taken");

  scale_mix_a: assert property (wr_to(PAC_ADDR_SCALE_CFG) |=>
    level_scale_select_o == $past(reg_wdata_i[5]) && level_four_mix_enable_o == $past(reg_wdata_i[6]))
    else $error("scale or mix bit wrong");

  offset_osd_a: assert property (wr_to(PAC_ADDR_SCALE_CFG) |=>
    output_black_offset_o == $past(reg_wdata_i[2:0]) && overlay_contrast_field_o == $past(reg_wdata_i[4:3]))
    else $error("offset or overlay contrast wrong");

  blank_power_a: assert property (wr_to(PAC_ADDR_GLOBAL) |=>
    global_blank_o == $past(reg_wdata_i[0]) && power_save_o == $past(reg_wdata_i[1]))
    else $error("blank or power save wrong");

  range_vblank_a: assert property (wr_to(PAC_ADDR_RANGE) |=>
    loop_freq_range_o == $past(reg_wdata_i[1:0]) && vertical_blank_enable_o == $past(reg_wdata_i[2]))
    else $error("range or vertical blank wrong");

  soft_reset_a: assert property (soft_rst_req |=> soft_rst_done)
    else $error("soft reset did not reload and clear");

  hold_value_a: assert property (!(ce_i && (reg_wr_i || soft_reset_o)) |=>
    $stable(red_gain_field_o) && $stable(level_one_code_o) && $stable(global_blank_o))
    else $error("register changed without write");

  read_back_a: assert property (ce_i && reg_rd_i && reg_addr_i == PAC_ADDR_GAIN_BLUE |=>
    reg_rdata_o == {1'b0, $past(blue_gain_field_o)}) else $error("read data mismatch");

  sequence soft_rst_cycle;
    soft_reset_o && ce_i;
  endsequence

  // every field the soft reset must reload, auto increment disable excluded
  sequence fields_at_defaults;
    blue_gain_field_o == PAC_GAIN_RST && green_gain_field_o == PAC_GAIN_RST &&
    red_gain_field_o == PAC_GAIN_RST && contrast_gain_field_o == PAC_CONTR_RST &&
    level_one_code_o == PAC_LEVEL_RST && level_two_code_o == PAC_LEVEL_RST &&
    level_three_code_o == PAC_LEVEL_RST && level_four_code_o == PAC_LEVEL_RST &&
    level_scale_select_o == PAC_SCALE_RST && level_four_mix_enable_o == PAC_MIX_RST &&
    overlay_contrast_field_o == PAC_OSD_RST && output_black_offset_o == PAC_OFFSET_RST &&
    global_blank_o == PAC_BLANK_RST && power_save_o == PAC_PSAVE_RST &&
    loop_freq_range_o == PAC_RANGE_RST && vertical_blank_enable_o == PAC_VBLANK_RST;
  endsequence

  blue_gain_a: assert property (wr_to(PAC_ADDR_GAIN_BLUE) |=>
    blue_gain_field_o == $past(reg_wdata_i[6:0])) else $error("blue gain not taken from write");

  green_gain_a: assert property (wr_to(PAC_ADDR_GAIN_GREEN) |=>
    green_gain_field_o == $past(reg_wdata_i[6:0])) else $error("green gain not taken from write");

  level_one_a: assert property (wr_to(PAC_ADDR_LEVEL_ONE) |=>
    level_one_code_o == $past(reg_wdata_i)) else $error("level one code not taken");

  level_two_a: assert property (wr_to(PAC_ADDR_LEVEL_TWO) |=>
    level_two_code_o == $past(reg_wdata_i)) else $error("level two code not taken");

  level_three_a: assert property (wr_to(PAC_ADDR_LEVEL_THR) |=>
    level_three_code_o == $past(reg_wdata_i)) else $error("level three code not taken");

  reset_clear_a: assert property (soft_rst_cycle |=> !soft_reset_o)
    else $error("soft reset did not clear itself");

  reset_reload_a: assert property (soft_rst_cycle |=> fields_at_defaults)
    else $error("soft reset left a field off its default");

  reset_keeps_inc_a: assert property (soft_rst_cycle |=> $stable(auto_inc_disable_o))
    else $error("soft reset touched auto increment disable");

  reset_pause_a: assert property (soft_reset_o && !ce_i |=> soft_reset_o)
    else $error("soft reset lost while clock enable low");

  freeze_state_a: assert property (!ce_i |=> $stable(st_q))
    else $error("state moved while clock enable low");

  rdata_hold_a: assert property (!(ce_i && reg_rd_i) |=> $stable(reg_rdata_o))
    else $error("read data changed without read");

  reserved_read_a: assert property (ce_i && reg_rd_i && reg_addr_i == PAC_ADDR_RANGE |=>
    reg_rdata_o[7:3] == 5'h00) else $error("reserved bits not read as zero");

endmodule // pac_regs

// ==== hdl/pac_pkg.sv ====
package pac_pkg;

  // register byte addresses as seen by the serial bus engine
  localparam logic [15:0] PAC_ADDR_GAIN_BLUE  = 16'h8430;
  localparam logic [15:0] PAC_ADDR_GAIN_GREEN = 16'h8431;
  localparam logic [15:0] PAC_ADDR_GAIN_RED   = 16'h8432;
  localparam logic [15:0] PAC_ADDR_CONTRAST   = 16'h8433;
  localparam logic [15:0] PAC_ADDR_LEVEL_ONE  = 16'h8434;
  localparam logic [15:0] PAC_ADDR_LEVEL_TWO  = 16'h8435;
  localparam logic [15:0] PAC_ADDR_LEVEL_THR  = 16'h8436;
  localparam logic [15:0] PAC_ADDR_LEVEL_FOUR = 16'h8437;
  localparam logic [15:0] PAC_ADDR_SCALE_CFG  = 16'h8438;
  localparam logic [15:0] PAC_ADDR_GLOBAL     = 16'h8439;
  localparam logic [15:0] PAC_ADDR_RANGE      = 16'h843E;
  localparam logic [15:0] PAC_ADDR_RESET_CTL  = 16'h843F;

  // field positions
  localparam int PAC_GAIN_MSB      = 6;
  localparam int PAC_OFFSET_LSB    = 0;
  localparam int PAC_OFFSET_MSB    = 2;
  localparam int PAC_OSD_LSB       = 3;
  localparam int PAC_OSD_MSB       = 4;
  localparam int PAC_SCALE_BIT     = 5;
  localparam int PAC_MIX_BIT       = 6;
  localparam int PAC_BLANK_BIT     = 0;
  localparam int PAC_PSAVE_BIT     = 1;
  localparam int PAC_RANGE_LSB     = 0;
  localparam int PAC_RANGE_MSB     = 1;
  localparam int PAC_VBLANK_BIT    = 2;
  localparam int PAC_SRESET_BIT    = 0;
  localparam int PAC_AI_DIS_BIT    = 6;

  // values after reset
  localparam logic [6:0] PAC_GAIN_RST   = 7'h00;
  localparam logic [6:0] PAC_CONTR_RST  = 7'h00;
  localparam logic [7:0] PAC_LEVEL_RST  = 8'h00;
  localparam logic       PAC_SCALE_RST  = 1'b0;
  localparam logic       PAC_MIX_RST    = 1'b0;
  localparam logic [1:0] PAC_OSD_RST    = 2'h0;
  localparam logic [2:0] PAC_OFFSET_RST = 3'h0;
  localparam logic       PAC_BLANK_RST  = 1'b0;
  localparam logic       PAC_PSAVE_RST  = 1'b0;
  localparam logic [1:0] PAC_RANGE_RST  = 2'h0;
  localparam logic       PAC_VBLANK_RST = 1'b0;
  localparam logic       PAC_AI_DIS_RST = 1'b0;
  localparam logic       PAC_SRESET_RST = 1'b0;
  localparam logic [7:0] PAC_RDATA_RST  = 8'h00;

  typedef struct packed {
    logic [6:0] gain_blue;
    logic [6:0] gain_green;
    logic [6:0] gain_red;
    logic [6:0] contrast;
    logic [7:0] level_one;
    logic [7:0] level_two;
    logic [7:0] level_three;
    logic [7:0] level_four;
    logic       scale_sel;
    logic       mix_en;
    logic [1:0] overlay_contrast;
    logic [2:0] black_offset;
    logic       blank;
    logic       power_save;
    logic [1:0] freq_range;
    logic       vblank_en;
    logic       ai_dis;
    logic       soft_rst;
    logic [7:0] rdata;
  } pac_state_t;

endpackage

// ==== test/pac_host_model.sv ====
`timescale 1ns/1ps
// stands in for the serial bus engine that turns bus traffic into byte strobes
module pac_host_model (
  input  wire logic        mclk_i,
  input  wire logic [7:0]  reg_rdata_i,
  output logic      [15:0] reg_addr_o,
  output logic      [7:0]  reg_wdata_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o
);
  initial begin
    reg_addr_o  = 16'h0000;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end

  // strobe held across exactly one sampling edge, one byte per address
  task automatic write_byte(input logic [15:0] addr, input logic [7:0] data);
    @(posedge mclk_i);
    #1;
    reg_addr_o  = addr;
    reg_wdata_o = data;
    reg_wr_o    = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~data; // stale data must never be picked up
  endtask

  task automatic read_byte(input logic [15:0] addr, output logic [7:0] data);
    @(posedge mclk_i);
    #1;
    reg_addr_o = addr;
    reg_rd_o   = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_rd_o   = 1'b0;
    reg_addr_o = ~addr;
    data       = reg_rdata_i;
  endtask
endmodule // pac_host_model

// ==== test/pac_regs_bench.sv ====
`timescale 1ns/1ps
module pac_regs_bench;
  import pac_pkg::*;
  logic        mclk_i, resetn_i, ce_i, wr, rd, scl, mix, blank, psave, vblank, ainc_dis, sreset;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, l1, l2, l3, l4;
  logic [6:0]  gb, gg, gr, gc;
  logic [1:0]  osd, rng;
  logic [2:0]  offs;
  int          error_cnt = 0;
  int          n_checks = 0;
  logic [15:0] addrs [11] = '{PAC_ADDR_GAIN_BLUE, PAC_ADDR_GAIN_GREEN, PAC_ADDR_GAIN_RED, PAC_ADDR_CONTRAST,
    PAC_ADDR_LEVEL_ONE, PAC_ADDR_LEVEL_TWO, PAC_ADDR_LEVEL_THR, PAC_ADDR_LEVEL_FOUR, PAC_ADDR_SCALE_CFG,
    PAC_ADDR_GLOBAL, PAC_ADDR_RANGE};

  pac_host_model host_u (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_wr_o(wr), .reg_rd_o(rd));
  pac_regs dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .blue_gain_field_o(gb), .green_gain_field_o(gg),
    .red_gain_field_o(gr), .contrast_gain_field_o(gc), .level_one_code_o(l1), .level_two_code_o(l2),
    .level_three_code_o(l3), .level_four_code_o(l4), .level_scale_select_o(scl), .level_four_mix_enable_o(mix),
    .overlay_contrast_field_o(osd), .output_black_offset_o(offs), .global_blank_o(blank),
    .power_save_o(psave), .loop_freq_range_o(rng), .vertical_blank_enable_o(vblank),
    .auto_inc_disable_o(ainc_dis), .soft_reset_o(sreset));

  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
    host_u.write_byte(a, d);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string name);
    logic [7:0] v;
    host_u.read_byte(a, v);
    check(name, 64'(exp), 64'(v));
  endtask

  task automatic t_defaults;
    check("fields_a", 64'h0, 64'({gb, gg, gr, gc, l1, l2, l3, l4}));
    check("fields_b", 64'h0, 64'({scl, mix, osd, offs, blank, psave, rng, vblank, ainc_dis, sreset}));
    foreach (addrs[i]) rd_chk(addrs[i], 8'h00, "reset_read");
  endtask

  task automatic t_gains;
    // back to back writes, no idle beyond the strobe gap
    wr_b(PAC_ADDR_GAIN_BLUE, 8'h7F);
    wr_b(PAC_ADDR_GAIN_GREEN, 8'h15);
    wr_b(PAC_ADDR_GAIN_RED, 8'h40);
    wr_b(PAC_ADDR_CONTRAST, 8'h2A);
    check("gains", 64'({7'h7F, 7'h15, 7'h40}), 64'({gb, gg, gr}));
    check("contrast", 64'h2A, 64'(gc));
    rd_chk(PAC_ADDR_GAIN_GREEN, 8'h15, "green_read");
    rd_chk(PAC_ADDR_CONTRAST, 8'h2A, "contrast_read");
    check("gains_held", 64'({7'h7F, 7'h15, 7'h40, 7'h2A}), 64'({gb, gg, gr, gc}));
  endtask

  task automatic t_levels;
    logic [7:0] vals [4] = '{8'hFF, 8'h00, 8'hA5, 8'h5A};
    for (int i = 0; i < 4; i++) wr_b(PAC_ADDR_LEVEL_ONE + 16'(i), vals[i]);
    check("levels", 64'({8'hFF, 8'h00, 8'hA5, 8'h5A}), 64'({l1, l2, l3, l4}));
    for (int i = 0; i < 4; i++) rd_chk(PAC_ADDR_LEVEL_ONE + 16'(i), vals[i], "level_read");
  endtask

  task automatic t_config;
    logic [7:0] vals [5] = '{8'h7F, 8'h00, 8'h55, 8'h2A, 8'h10};
    foreach (vals[i]) begin
      wr_b(PAC_ADDR_SCALE_CFG, vals[i]);
      check("scale", 64'(vals[i][5]), 64'(scl));
      check("mix", 64'(vals[i][6]), 64'(mix));
      check("offset", 64'(vals[i][2:0]), 64'(offs));
      check("overlay", 64'(vals[i][4:3]), 64'(osd));
      rd_chk(PAC_ADDR_SCALE_CFG, vals[i], "config_read");
    end
  endtask

  task automatic t_ctrl;
    for (int v = 0; v < 8; v++) begin
      wr_b(PAC_ADDR_GLOBAL, 8'(v & 3));
      wr_b(PAC_ADDR_RANGE, 8'(v));
      check("blank", 64'(v & 1), 64'(blank));
      check("psave", 64'((v >> 1) & 1), 64'(psave));
      check("range", 64'(v & 3), 64'(rng));
      check("vblank", 64'((v >> 2) & 1), 64'(vblank));
    end
    rd_chk(PAC_ADDR_RANGE, 8'h07, "range_read");
    rd_chk(PAC_ADDR_GLOBAL, 8'h03, "global_read");
  endtask

  task automatic t_hold;
    wr_b(16'h843A, 8'h33);
    rd_chk(16'h843A, 8'h00, "unmapped_read");
    ce_i = 1'b0; // frozen state must swallow this write and this read
    wr_b(PAC_ADDR_GAIN_GREEN, 8'h01);
    rd_chk(PAC_ADDR_GAIN_GREEN, 8'h00, "frozen_read");
    ce_i = 1'b1;
    check("gains_kept", 64'({7'h7F, 7'h15, 7'h40, 7'h2A}), 64'({gb, gg, gr, gc}));
    rd_chk(PAC_ADDR_GAIN_GREEN, 8'h15, "green_kept");
  endtask

  task automatic t_soft_reset;
    // every config field except level two nonzero first, so the reload is visible
    wr_b(PAC_ADDR_SCALE_CFG, 8'h7F);
    wr_b(PAC_ADDR_RESET_CTL, 8'h40);
    check("auto_inc", 64'h1, 64'(ainc_dis));
    wr_b(PAC_ADDR_RESET_CTL, 8'h41);
    check("reset_pulse", 64'h1, 64'(sreset));
    @(posedge mclk_i);
    #1;
    check("reset_clear", 64'h0, 64'(sreset));
    check("reloaded_a", 64'h0, 64'({gb, gg, gr, gc, l1, l2, l3, l4}));
    check("reloaded_b", 64'h0, 64'({scl, mix, osd, offs, blank, psave, rng, vblank}));
    check("auto_inc_kept", 64'h1, 64'(ainc_dis));
    rd_chk(PAC_ADDR_GAIN_RED, 8'h00, "red_after_reset");
  endtask

  task automatic t_async_reset;
    wr_b(PAC_ADDR_LEVEL_TWO, 8'hC3);
    wr_b(PAC_ADDR_GLOBAL, 8'h03);
    rd_chk(PAC_ADDR_LEVEL_TWO, 8'hC3, "level_two_read");
    @(posedge mclk_i);
    #1;
    resetn_i = 1'b0;
    #1;
    // asynchronous: everything clears before the next edge
    check("async_clear", 64'h0, 64'({l2, blank, psave, ainc_dis, rdata}));
    @(posedge mclk_i);
    #1;
    resetn_i = 1'b1;
    check("after_release", 64'h0, 64'({l2, blank, psave, ainc_dis, rdata}));
    rd_chk(PAC_ADDR_LEVEL_TWO, 8'h00, "level_two_after_reset");
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end

  initial begin
    resetn_i = 1'b0;
    ce_i     = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    resetn_i = 1'b1;
    t_defaults();
    t_gains();
    t_levels();
    t_config();
    t_ctrl();
    t_hold();
    t_soft_reset();
    t_async_reset();
    complete_run();
  end
endmodule // pac_regs_bench
